// >>> ssp_cfg.svh
/*
  Constants of the serial port status, prescale and interrupt register bank:
  register offsets, field positions, reset values and FIFO levels.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SSP_ADDR_W 12
`define SSP_OFF_STATUS 12'h00c
`define SSP_OFF_PRESCALE 12'h010
`define SSP_OFF_MASK 12'h014
`define SSP_OFF_RAW 12'h018
`define SSP_OFF_MASKED 12'h01c
`define SSP_OFF_CLEAR 12'h020

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSP_ST_BUSY 4
`define SSP_ST_RX_FULL 3
`define SSP_ST_RX_NE 2
`define SSP_ST_TX_SPACE 1
`define SSP_ST_TX_EMPTY 0
`define SSP_IRQ_TX_LEVEL 3
`define SSP_IRQ_RX_LEVEL 2
`define SSP_IRQ_RX_TIMEOUT 1
`define SSP_IRQ_RX_OVERFLOW 0

// ----------------------------------------------------------------
// Reset values and FIFO levels
// ----------------------------------------------------------------
`define SSP_STATUS_RST 5'h03
`define SSP_PRESCALE_RST 8'h02
`define SSP_MASK_RST 4'h0
`define SSP_RAW_RST 4'h8
`define SSP_FIFO_DEPTH 4'h8
`define SSP_FIFO_HALF 4'h4

`endif

// >>> ssp_pkg.sv
/*
  Types of the serial port register bank: engine status carrier and the
  APB slave states. Assumes ssp_cfg.svh for the numbers.
*/
package ssp_pkg;

  // Live state reported by the serial engine on the same clock
  typedef struct packed {
    logic [3:0] tx_level;
    logic [3:0] rx_level;
    logic shifting;
    logic rx_timeout_evt;
    logic rx_overrun_evt;
  } ssp_engine_s;

  // APB slave phases
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b01,
    SSP_RESP = 2'b10
  } ssp_apb_e;

endpackage : ssp_pkg

// >>> ssp_regs.sv
/*
  Status, clock prescale and interrupt reporting registers of a synchronous
  serial port, as an APB slave. Assumes the serial engine runs on clk and
  reports FIFO levels, shifter activity and one-cycle event pulses.
*/
// The APB register port was decided locally.
// Operation
// - Busy bit 4 is set while shifting or transmit FIFO holds data.
// - Status bit 3 is set exactly when the receive FIFO is full.
// - Status bit 2 is set when the receive FIFO is not empty.
// - Status bit 1 is set while the transmit FIFO has free space.
// - Status bit 0 is set when transmit FIFO is empty; status read-only.
// - The 8-bit prescale divisor divides the system clock for bit timing.
// - Divisor bit 0 is held at zero, odd writes read back even.
// - Mask bits: one enables, zero masks, readable, cleared at reset.
// - Mask bits: 3 tx level, 2 rx level, 1 rx timeout, 0 overrun.
// - Raw status shows unmasked sources at mask positions, writes ignored.
// - Raw bit 3 set while transmit FIFO at or below half; resets 1.
// - Raw bit 2 shows receive FIFO half level condition, resets 0.
// - Raw bit 1 set by a receive timeout event, resets 0.
// - Raw bit 0 set when data arrives into a full receive FIFO.
// - Masked status is raw AND mask; writes to it do nothing.
// - All masked status bits read zero after reset.
// - Writing one to clear bits 1 or 0 clears timeout or overrun.
`include "ssp_cfg.svh"

module ssp_regs (
  // Clock, reset and freeze
  input logic clk,
  input logic rst,
  input logic ce,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [`SSP_ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial engine
  input ssp_pkg::ssp_engine_s engine,
  output logic [7:0] prescale_divisor,
  output logic prescale_tick,
  // Interrupt request
  output logic irq
);
  import ssp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ssp_apb_e apb_state;
  logic [4:0] port_status;
  logic [3:0] irq_mask;
  logic [3:0] raw_status;
  logic [7:0] prescale_cnt;
  logic [4:0] next_status;
  logic [3:0] next_raw;
  logic [31:0] next_rdata;
  logic next_err;
  logic bus_done;
  logic wr_fire;
  logic clr_timeout;
  logic clr_overflow;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // A transfer completes on the edge where pready is seen high
  assign bus_done = psel & penable & pready;
  assign wr_fire = bus_done & pwrite;
  // Clear strobes act only on ones; zeros leave the flags alone
  assign clr_timeout = wr_fire & (paddr == `SSP_OFF_CLEAR)
    & pwdata[`SSP_IRQ_RX_TIMEOUT];
  assign clr_overflow = wr_fire & (paddr == `SSP_OFF_CLEAR)
    & pwdata[`SSP_IRQ_RX_OVERFLOW];

  // ----------------------------------------------------------------
  // Live status
  // ----------------------------------------------------------------
  // Recomputed from the engine each cycle, never latched
  always_comb
  begin
    next_status = '0;
    next_status[`SSP_ST_BUSY] = engine.shifting
      | (engine.tx_level != 4'h0);
    next_status[`SSP_ST_RX_FULL] =
      (engine.rx_level == `SSP_FIFO_DEPTH);
    next_status[`SSP_ST_RX_NE] = (engine.rx_level != 4'h0);
    next_status[`SSP_ST_TX_SPACE] =
      (engine.tx_level != `SSP_FIFO_DEPTH);
    next_status[`SSP_ST_TX_EMPTY] = (engine.tx_level == 4'h0);
  end

  // Status register, one cycle behind the engine
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port_status <= `SSP_STATUS_RST;
    end
    else if (ce)
    begin
      port_status <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // Raw interrupt sources
  // ----------------------------------------------------------------
  // Level sources follow the FIFOs; event sources are sticky and an
  // event in the same cycle as its clear wins, so nothing is lost
  always_comb
  begin
    next_raw = raw_status;
    next_raw[`SSP_IRQ_TX_LEVEL] =
      (engine.tx_level <= `SSP_FIFO_HALF);
    next_raw[`SSP_IRQ_RX_LEVEL] =
      (engine.rx_level >= `SSP_FIFO_HALF);
    if (clr_timeout)
    begin
      next_raw[`SSP_IRQ_RX_TIMEOUT] = 1'b0;
    end
    if (engine.rx_timeout_evt)
    begin
      next_raw[`SSP_IRQ_RX_TIMEOUT] = 1'b1;
    end
    if (clr_overflow)
    begin
      next_raw[`SSP_IRQ_RX_OVERFLOW] = 1'b0;
    end
    if (engine.rx_overrun_evt)
    begin
      next_raw[`SSP_IRQ_RX_OVERFLOW] = 1'b1;
    end
  end

  // Raw status flops; only ones written to the clear register reach them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      raw_status <= `SSP_RAW_RST;
    end
    else if (ce)
    begin
      raw_status <= next_raw;
    end
  end

  // ----------------------------------------------------------------
  // Mask and interrupt output
  // ----------------------------------------------------------------
  // Mask register, all sources masked after reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_mask <= `SSP_MASK_RST;
    end
    else if (ce && wr_fire && paddr == `SSP_OFF_MASK)
    begin
      irq_mask <= pwdata[3:0];
    end
  end

  // Request is registered, so it trails the raw flags by one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else if (ce)
    begin
      irq <= |(raw_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Clock prescaler
  // ----------------------------------------------------------------
  // Divisor register; bit 0 cannot be stored, so odd writes read even
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prescale_divisor <= `SSP_PRESCALE_RST;
    end
    else if (ce && wr_fire && paddr == `SSP_OFF_PRESCALE)
    begin
      prescale_divisor <= {pwdata[7:1], 1'b0};
    end
  end

  // One tick every divisor cycles. A zero divisor, which software must
  // not program, wraps the counter and gives a tick every 256 cycles.
  // The divisor is not resynchronised: change it only while disabled.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prescale_cnt <= 8'h00;
      prescale_tick <= 1'b0;
    end
    else if (ce)
    begin
      if (prescale_cnt >= prescale_divisor - 8'h01)
      begin
        prescale_cnt <= 8'h00;
        prescale_tick <= 1'b1;
      end
      else
      begin
        prescale_cnt <= prescale_cnt + 8'h01;
        prescale_tick <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and APB answer
  // ----------------------------------------------------------------
  // Read mux; reserved bits and write-only clear read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `SSP_OFF_STATUS: next_rdata[4:0] = port_status;
      `SSP_OFF_PRESCALE: next_rdata[7:0] = prescale_divisor;
      `SSP_OFF_MASK: next_rdata[3:0] = irq_mask;
      `SSP_OFF_RAW: next_rdata[3:0] = raw_status;
      `SSP_OFF_MASKED: next_rdata[3:0] = raw_status & irq_mask;
      `SSP_OFF_CLEAR: next_rdata = 32'h0000_0000;
      default: next_err = 1'b1;
    endcase
  end

  // One wait state: pready rises the cycle after the access phase opens
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      apb_state <= SSP_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      case (apb_state)
        SSP_IDLE:
        begin
          if (psel && penable)
          begin
            apb_state <= SSP_RESP;
            pready <= 1'b1;
            pslverr <= next_err;
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
          end
        end
        SSP_RESP:
        begin
          apb_state <= SSP_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= 32'h0000_0000;
        end
        default:
        begin
          apb_state <= SSP_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_busy;
    ce |=> port_status[`SSP_ST_BUSY] ==
      ($past(engine.shifting) || $past(engine.tx_level) != 4'h0);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy flag does not follow engine");

  property p_rx_full;
    ce |=> port_status[`SSP_ST_RX_FULL] ==
      ($past(engine.rx_level) == `SSP_FIFO_DEPTH);
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("rx full flag wrong");

  property p_rx_ne;
    ce |=> port_status[`SSP_ST_RX_NE] == ($past(engine.rx_level) != 4'h0);
  endproperty
  a_rx_ne: assert property (p_rx_ne)
    else $error("rx not empty flag wrong");

  property p_tx_flags;
    ce |=> port_status[`SSP_ST_TX_SPACE] ==
      ($past(engine.tx_level) != `SSP_FIFO_DEPTH)
      && port_status[`SSP_ST_TX_EMPTY] == ($past(engine.tx_level) == 4'h0);
  endproperty
  a_tx_flags: assert property (p_tx_flags)
    else $error("tx space or empty flag wrong");

  property p_tick_gap;
    ce && prescale_tick && prescale_divisor == 8'h02 &&
      $past(prescale_divisor) == 8'h02 |=> ce |-> !prescale_tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("prescale tick too frequent");

  property p_div_even;
    prescale_divisor[0] == 1'b0;
  endproperty
  a_div_even: assert property (p_div_even)
    else $error("divisor bit 0 not zero");

  property p_mask_write;
    ce && wr_fire && paddr == `SSP_OFF_MASK |=> irq_mask == $past(pwdata[3:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write lost");

  property p_tx_level_raw;
    ce |=> raw_status[`SSP_IRQ_TX_LEVEL] ==
      ($past(engine.tx_level) <= `SSP_FIFO_HALF);
  endproperty
  a_tx_level_raw: assert property (p_tx_level_raw)
    else $error("tx level raw flag wrong");

  property p_overflow_set;
    ce && engine.rx_overrun_evt |=> raw_status[`SSP_IRQ_RX_OVERFLOW];
  endproperty
  a_overflow_set: assert property (p_overflow_set)
    else $error("overrun event not latched");

  property p_timeout_clear;
    ce && clr_timeout && !engine.rx_timeout_evt |=>
      !raw_status[`SSP_IRQ_RX_TIMEOUT];
  endproperty
  a_timeout_clear: assert property (p_timeout_clear)
    else $error("timeout flag not cleared");

  property p_irq;
    ce |=> irq == $past(|(raw_status & irq_mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq does not match masked status");

  property p_answer;
    ce && psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("apb answer not one wait state");

  property p_rx_level_raw;
    ce |=> raw_status[`SSP_IRQ_RX_LEVEL] ==
      ($past(engine.rx_level) >= `SSP_FIFO_HALF);
  endproperty
  a_rx_level_raw: assert property (p_rx_level_raw)
    else $error("rx level raw flag wrong");

  property p_timeout_set;
    ce && engine.rx_timeout_evt |=> raw_status[`SSP_IRQ_RX_TIMEOUT];
  endproperty
  a_timeout_set: assert property (p_timeout_set)
    else $error("timeout event not latched");

endmodule : ssp_regs

// >>> ssp_regs_tb_top.sv
/*
  Self-checking bench of the serial port status, prescale and interrupt
  register bank. Assumes ssp_cfg.svh and ssp_pkg, one 50 MHz clock and a
  bench that stands in for both the APB master and the serial engine.
*/
`include "ssp_cfg.svh"

module ssp_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`SSP_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ssp_engine_s engine = '0;
  logic [7:0] prescale_divisor;
  logic prescale_tick;
  logic irq;
  int n_fail = 0;
  int total_checks = 0;
  logic [31:0] st_exp [6] = '{32'h03, 32'h12, 32'h1c, 32'h17, 32'h16, 32'h16};
  logic [31:0] raw_exp [6] = '{32'h8, 32'h8, 32'h4, 32'h8, 32'hc, 32'h0};
  logic [3:0] tx_tab [6] = '{4'h0, 4'h3, 4'h8, 4'h0, 4'h4, 4'h5};
  logic [3:0] rx_tab [6] = '{4'h0, 4'h0, 4'h8, 4'h1, 4'h4, 4'h3};
  logic sh_tab [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  ssp_regs dut (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .engine(engine), .prescale_divisor(prescale_divisor), .prescale_tick(prescale_tick),
    .irq(irq)
  );

  // Free-running system clock, 20 ns period
  initial
  begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Comparison and bus tasks
  // ----------------------------------------------------------------
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // One APB transfer; the request stands until the rising edge that sees
  // pready high, and read data and error are taken at that same edge.
  // No wait count is assumed: only the watchdog ends a hung access.
  task apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b0, a, '0, r, e);
    chk_word(r, exp);
    chk_bit(e, exp_err);
  endtask : rd_chk

  task wr_chk(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, a, d, r, e);
    chk_bit(e, exp_err);
  endtask : wr_chk

  // Engine stimulus; events are one-cycle pulses
  task set_eng(input logic [3:0] tx, input logic [3:0] rx, input logic sh);
    @(posedge clk);
    engine.tx_level <= tx;
    engine.rx_level <= rx;
    engine.shifting <= sh;
  endtask : set_eng

  task pulse_evt(input logic tmo, input logic ovr);
    @(posedge clk);
    engine.rx_timeout_evt <= tmo;
    engine.rx_overrun_evt <= ovr;
    @(posedge clk);
    engine.rx_timeout_evt <= 1'b0;
    engine.rx_overrun_evt <= 1'b0;
  endtask : pulse_evt

  task tick_period(input logic [31:0] exp);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (prescale_tick !== 1'b1 && n < 600);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (prescale_tick !== 1'b1 && n < 600);
    chk_word(32'(n), exp);
  endtask : tick_period

  task reset_values;
    rd_chk(`SSP_OFF_STATUS, 32'h03, 1'b0);
    rd_chk(`SSP_OFF_PRESCALE, 32'h02, 1'b0);
    rd_chk(`SSP_OFF_MASK, 32'h0, 1'b0);
    rd_chk(`SSP_OFF_RAW, 32'h8, 1'b0);
    rd_chk(`SSP_OFF_MASKED, 32'h0, 1'b0);
    chk_bit(irq, 1'b0);
  endtask : reset_values

  task report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    // Live status and level flags for a table of FIFO fills
    for (int i = 0; i < 6; i++)
    begin
      set_eng(tx_tab[i], rx_tab[i], sh_tab[i]);
      rd_chk(`SSP_OFF_STATUS, st_exp[i], 1'b0);
      rd_chk(`SSP_OFF_RAW, raw_exp[i], 1'b0);
    end
    set_eng(4'h0, 4'h0, 1'b0);
    // Read-only registers keep their value under writes
    wr_chk(`SSP_OFF_STATUS, 32'hffffffff, 1'b0);
    wr_chk(`SSP_OFF_RAW, 32'hffffffff, 1'b0);
    wr_chk(`SSP_OFF_MASKED, 32'hffffffff, 1'b0);
    rd_chk(`SSP_OFF_STATUS, 32'h03, 1'b0);
    rd_chk(`SSP_OFF_RAW, 32'h8, 1'b0);
    rd_chk(`SSP_OFF_MASKED, 32'h0, 1'b0);
    // Divisor: bit 0 forced low, reserved bits dropped, tick spacing
    wr_chk(`SSP_OFF_PRESCALE, 32'h37, 1'b0);
    rd_chk(`SSP_OFF_PRESCALE, 32'h36, 1'b0);
    chk_word({24'h0, prescale_divisor}, 32'h36);
    wr_chk(`SSP_OFF_PRESCALE, 32'h1ff, 1'b0);
    rd_chk(`SSP_OFF_PRESCALE, 32'hfe, 1'b0);
    wr_chk(`SSP_OFF_PRESCALE, 32'h06, 1'b0);
    tick_period(32'd6);
    // Mask layout and masked status
    wr_chk(`SSP_OFF_MASK, 32'hfffffff5, 1'b0);
    rd_chk(`SSP_OFF_MASK, 32'h5, 1'b0);
    rd_chk(`SSP_OFF_MASKED, 32'h0, 1'b0);
    chk_bit(irq, 1'b0);
    pulse_evt(1'b0, 1'b1);
    rd_chk(`SSP_OFF_RAW, 32'h9, 1'b0);
    rd_chk(`SSP_OFF_MASKED, 32'h1, 1'b0);
    chk_bit(irq, 1'b1);
    pulse_evt(1'b1, 1'b0);
    rd_chk(`SSP_OFF_RAW, 32'hb, 1'b0);
    rd_chk(`SSP_OFF_MASKED, 32'h1, 1'b0);
    // Clear register: zeros do nothing, ones clear one event each
    wr_chk(`SSP_OFF_CLEAR, 32'h0, 1'b0);
    rd_chk(`SSP_OFF_RAW, 32'hb, 1'b0);
    wr_chk(`SSP_OFF_CLEAR, 32'h1, 1'b0);
    rd_chk(`SSP_OFF_RAW, 32'ha, 1'b0);
    chk_bit(irq, 1'b0);
    wr_chk(`SSP_OFF_CLEAR, 32'h2, 1'b0);
    rd_chk(`SSP_OFF_RAW, 32'h8, 1'b0);
    // A frozen block must not latch an event that arrives while ce is low
    @(posedge clk);
    ce <= 1'b0;
    pulse_evt(1'b0, 1'b1);
    ce <= 1'b1;
    rd_chk(`SSP_OFF_RAW, 32'h8, 1'b0);
    wr_chk(`SSP_OFF_MASK, 32'h8, 1'b0);
    rd_chk(`SSP_OFF_MASKED, 32'h8, 1'b0);
    chk_bit(irq, 1'b1);
    set_eng(4'h5, 4'h4, 1'b0);
    wr_chk(`SSP_OFF_MASK, 32'h4, 1'b0);
    rd_chk(`SSP_OFF_MASKED, 32'h4, 1'b0);
    // Unmapped places answer with an error and read zero
    rd_chk(12'h024, 32'h0, 1'b1);
    wr_chk(12'h000, 32'h5a5a5a5a, 1'b1);
    rd_chk(12'h000, 32'h0, 1'b1);
    rd_chk(`SSP_OFF_CLEAR, 32'h0, 1'b0);
    // Second reset in mid-run brings every register back
    set_eng(4'h0, 4'h0, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    report_and_stop();
  end
endmodule : ssp_regs_tb_top
